//--- logic/cpm_pkg.sv
// package for the core power mode controller: register map, field
// positions, timing counts and shared types.
// assumes a 200 MHz aclk and a 32-bit axi4-lite register port.
`default_nettype none
package cpm_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned DET_TIMEOUT_US   = 100;
  localparam int unsigned DET_TIMEOUT_CYC  = DET_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned WDOG_DEF_CYC     = 65536;
  localparam int unsigned RST_SEQ_CYC      = 4;

  localparam logic [7:0]  OFS_PCTL    = 8'h00;
  localparam logic [7:0]  OFS_CFG     = 8'h04;
  localparam logic [7:0]  OFS_STAT    = 8'h08;
  localparam logic [7:0]  OFS_INT     = 8'h0C;
  localparam int unsigned PCTL_IDLE   = 0;
  localparam int unsigned PCTL_STOP   = 1;
  localparam int unsigned CFG_DET_EN  = 0;
  localparam int unsigned CFG_WDOG_EN = 1;
  localparam logic [7:0]  PCTL_RST    = 8'h00;
  localparam logic [1:0]  CFG_RST     = 2'h0;
  localparam logic [15:0] RESET_PC    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CPM_RUN    = 3'h0,
    CPM_FINISH = 3'h1,
    CPM_IDLE   = 3'h2,
    CPM_STOP   = 3'h3,
    CPM_RESET  = 3'h4
  } cpm_mode_e;

  typedef struct packed {
    logic        rst_int;
    logic [1:0]  cause;
  } cpm_rst_s;
endpackage : cpm_pkg
`default_nettype wire

//--- logic/cpm_timeout.sv
// down-counter that fires a one-cycle pulse after a programmable
// number of cycles while armed; used for the watchdog and clock detector.
// assumes arm is synchronous to aclk.
`default_nettype none
module cpm_timeout
  import cpm_pkg::*;
#(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic arm,
  output logic      fire
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        fire;
  } cpm_to_s;
  cpm_to_s st_r;
  cpm_to_s st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.fire = 1'b0;
    if (!arm) begin
      st_nxt.cnt = 32'(CYCLES - 1);
    end else if (st_r.cnt == 32'h0) begin
      st_nxt.fire = 1'b1;
      st_nxt.cnt  = 32'(CYCLES - 1);
    end else begin
      st_nxt.cnt = st_r.cnt - 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '{cnt: 32'(CYCLES - 1), fire: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fire = st_r.fire;
endmodule : cpm_timeout
`default_nettype wire

//--- logic/cpm_sync.sv
// two-flop synchroniser for a pin-level input.
// assumes din is asynchronous to aclk.
`default_nettype none
module cpm_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } cpm_sy_s;
  cpm_sy_s st_r;
  cpm_sy_s st_nxt;

  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;
endmodule : cpm_sync
`default_nettype wire

//--- logic/cpm_core_power_mode.sv
// core power mode controller: idle and stop sequencing, wake and
// reset handling, watchdog and missing-clock timeouts, axi4-lite regs.
// assumes the core reports instruction retirement and interrupt state
// on aclk; the external reset pin is asynchronous and synchronised here.
//
// Notes on behaviour
// - setting idle bit halts fetch after the setting instruction retires
// - in idle, clocks and peripherals run and all state is kept
// - enabled interrupt in idle clears idle bit and resumes cpu
// - after the handler returns, execution resumes after the idle write
// - reset ending idle runs reset sequence, fetch from address 0x0000
// - enabled watchdog eventually resets the core out of idle
// - setting stop bit enters stop after the setting instruction
// - stop halts cpu and oscillators; only an enabled clock detector and an enabled watchdog stay alive
// - stop ends only by reset, then reset sequence from 0x0000
// - enabled clock detector resets the core after its timeout in stop
`default_nettype none
module cpm_core_power_mode
  import cpm_pkg::*;
#(
  parameter int unsigned WDOG_CYC = WDOG_DEF_CYC,
  parameter int unsigned DET_CYC  = DET_TIMEOUT_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        rst_pin_n,
  input  wire logic        insn_retire,
  input  wire logic [7:0]  irq_pending,
  input  wire logic [7:0]  irq_enable,
  input  wire logic        wdog_kick,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cpu_halt,
  output logic             osc_enable,
  output logic             periph_enable,
  output logic             core_reset,
  output logic             pc_load,
  output logic [15:0]      pc_value,
  output logic [1:0]       mode_state
);
  typedef struct packed {
    cpm_mode_e   mode;
    logic [7:0]  pctl;
    logic [1:0]  cfg;
    cpm_rst_s    rst;
    logic [2:0]  seq_cnt;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        halt;
    logic        osc;
    logic        periph;
    logic        pc_load;
    logic        awrdy;
    logic        wrdy;
    logic        arrdy;
    logic [1:0]  ms;
  } cpm_st_s;

  cpm_st_s st_r;
  cpm_st_s st_nxt;
  logic    pin_rst_n;
  logic    wdog_fire;
  logic    det_fire;
  logic    wdog_arm;
  logic    det_arm;
  logic    wake_irq;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit

  // mode_state shows run, idle and stop; the transient states read as run
  function automatic logic [1:0] mode_code(input cpm_mode_e m);
    if (m == CPM_IDLE) begin
      mode_code = 2'h1;
    end else if (m == CPM_STOP) begin
      mode_code = 2'h2;
    end else begin
      mode_code = 2'h0;
    end
  endfunction : mode_code

  cpm_sync u_rst_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (rst_pin_n),
    .dout    (pin_rst_n)
  );

  // watchdog keeps counting in idle; a kick restarts it
  assign wdog_arm = st_r.cfg[CFG_WDOG_EN] && !wdog_kick
                    && st_r.mode != CPM_RESET;
  // the detector models the stopped system clock, so it runs only in stop
  assign det_arm = st_r.cfg[CFG_DET_EN] && st_r.mode == CPM_STOP;

  cpm_timeout #(.CYCLES(WDOG_CYC)) u_wdog (
    .aclk    (aclk),
    .aresetn (aresetn),
    .arm     (wdog_arm),
    .fire    (wdog_fire)
  );

  cpm_timeout #(.CYCLES(DET_CYC)) u_det (
    .aclk    (aclk),
    .aresetn (aresetn),
    .arm     (det_arm),
    .fire    (det_fire)
  );

  assign wake_irq = |(irq_pending & irq_enable);

  always_comb begin
    logic        do_wr;
    logic        do_rd;
    logic [31:0] wd;
    logic        any_rst;
    do_wr  = 1'b0;
    do_rd  = 1'b0;
    wd     = 32'h0;
    any_rst = 1'b0;
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;

    // axi4-lite write: address and data accepted in either order
    if (s_axi_awvalid && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      do_wr         = 1'b1;
      wd            = st_r.w_data;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      if (!hit(st_r.aw_addr, OFS_PCTL) && !hit(st_r.aw_addr, OFS_CFG)) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid) begin
      do_rd         = 1'b1;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = 32'h0;
      if (hit(s_axi_araddr, OFS_PCTL)) begin
        st_nxt.rdata = {24'h0, st_r.pctl};
      end else if (hit(s_axi_araddr, OFS_CFG)) begin
        st_nxt.rdata = {30'h0, st_r.cfg};
      end else if (hit(s_axi_araddr, OFS_STAT)) begin
        st_nxt.rdata = {27'h0, st_r.rst.cause, 3'(st_r.mode)};
      end else if (hit(s_axi_araddr, OFS_INT)) begin
        st_nxt.rdata = {16'h0, irq_enable, irq_pending};
      end else begin
        st_nxt.rresp = RESP_SLVERR;
      end
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    if (do_wr && hit(st_r.aw_addr, OFS_PCTL) && st_r.w_strb[0]) begin
      st_nxt.pctl = wd[7:0];
    end
    if (do_wr && hit(st_r.aw_addr, OFS_CFG) && st_r.w_strb[0]) begin
      st_nxt.cfg = wd[1:0];
    end

    any_rst = !pin_rst_n || wdog_fire || det_fire;

    unique case (st_r.mode)
      CPM_RUN: begin
        if (st_nxt.pctl[PCTL_IDLE] || st_nxt.pctl[PCTL_STOP]) begin
          st_nxt.mode = CPM_FINISH;
        end
      end
      CPM_FINISH: begin
        // wait for the writing instruction to retire before halting
        if (insn_retire) begin
          if (st_r.pctl[PCTL_STOP]) begin
            st_nxt.mode   = CPM_STOP;
            st_nxt.halt   = 1'b1;
            st_nxt.osc    = 1'b0;
            st_nxt.periph = 1'b0;
          end else begin
            st_nxt.mode = CPM_IDLE;
            st_nxt.halt = 1'b1;
          end
        end
      end
      CPM_IDLE: begin
        if (wake_irq) begin
          // pc is untouched, so the return lands after the idle write
          st_nxt.pctl[PCTL_IDLE] = 1'b0;
          st_nxt.mode            = CPM_RUN;
          st_nxt.halt            = 1'b0;
        end
      end
      CPM_STOP: begin
        // interrupts are ignored here; only a reset leaves stop
        st_nxt.mode = CPM_STOP;
      end
      CPM_RESET: begin
        if (st_r.seq_cnt == 3'h0) begin
          st_nxt.mode        = CPM_RUN;
          st_nxt.rst.rst_int = 1'b0;
          st_nxt.halt        = 1'b0;
          st_nxt.pc_load     = 1'b1;
        end else begin
          st_nxt.seq_cnt = st_r.seq_cnt - 3'h1;
        end
      end
      default: begin
        st_nxt.mode = CPM_RESET;
      end
    endcase

    if (any_rst) begin
      st_nxt.mode        = CPM_RESET;
      st_nxt.seq_cnt     = 3'(RST_SEQ_CYC - 1);
      st_nxt.pctl        = PCTL_RST;
      st_nxt.rst.rst_int = 1'b1;
      st_nxt.rst.cause   = !pin_rst_n ? 2'h1 : (wdog_fire ? 2'h2 : 2'h3);
      st_nxt.halt        = 1'b1;
      st_nxt.osc         = 1'b1;
      st_nxt.periph      = 1'b1;
    end
    if (do_rd) begin
      st_nxt.rvalid = 1'b1;
    end
    // readies and mode code are registered so every output but the constant pc_value leaves a flop
    st_nxt.awrdy = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wrdy  = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arrdy = !st_nxt.rvalid;
    st_nxt.ms    = mode_code(st_nxt.mode);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= '0;
      st_r.mode    <= CPM_RUN;
      st_r.pctl    <= PCTL_RST;
      st_r.cfg     <= CFG_RST;
      st_r.osc     <= 1'b1;
      st_r.periph  <= 1'b1;
      st_r.pc_load <= 1'b1;
      st_r.awrdy   <= 1'b1;
      st_r.wrdy    <= 1'b1;
      st_r.arrdy   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awrdy;
  assign s_axi_wready  = st_r.wrdy;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arrdy;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign cpu_halt      = st_r.halt;
  assign osc_enable    = st_r.osc;
  assign periph_enable = st_r.periph;
  assign core_reset    = st_r.rst.rst_int;
  assign pc_load       = st_r.pc_load;
  assign pc_value      = RESET_PC;
  assign mode_state    = st_r.ms;
endmodule : cpm_core_power_mode
`default_nettype wire

//--- tb/cpm_core_power_mode_sva.sv
// port assertions for the core power mode controller.
// assumes aclk with a synchronous active-low aresetn.
`default_nettype none
module cpm_core_power_mode_sva
  import cpm_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  irq_pending,
  input wire logic [7:0]  irq_enable,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        cpu_halt,
  input wire logic        osc_enable,
  input wire logic        periph_enable,
  input wire logic        core_reset,
  input wire logic        pc_load,
  input wire logic [15:0] pc_value,
  input wire logic [1:0]  mode_state
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic wake;
  assign wake = |(irq_pending & irq_enable);
  // the core is held four cycles before the vector load
  sequence s_rst_hold;
    (core_reset && cpu_halt) [*4];
  endsequence
  sequence s_boot;
    ##[1:3] pc_load;
  endsequence

  chk_idle_alive: assert property (
    mode_state == 2'd1 |-> cpu_halt && osc_enable && periph_enable)
    else $error("idle lost clocks or let the cpu run");
  chk_idle_wake: assert property (
    mode_state == 2'd1 && wake |-> ##[1:3] mode_state == 2'd0)
    else $error("enabled interrupt did not end idle");
  chk_idle_masked: assert property (
    mode_state == 2'd1 && !wake && !core_reset |=>
      mode_state != 2'd0 || core_reset)
    else $error("idle ended with no enabled interrupt");
  chk_stop_quiet: assert property (
    mode_state == 2'd2 && $past(mode_state) == 2'd2 && !core_reset |->
      cpu_halt && !osc_enable && !periph_enable)
    else $error("stop left clocks running");
  chk_stop_hold: assert property (
    mode_state == 2'd2 && !core_reset |=> mode_state == 2'd2 || core_reset)
    else $error("stop ended without a reset");
  chk_rst_seq: assert property (
    $rose(core_reset) |-> s_rst_hold ##0 s_boot)
    else $error("reset sequence not followed by vector load");
  chk_rst_len: assert property (
    $fell(core_reset) |-> $past(core_reset, 4))
    else $error("reset sequence too short");
  chk_vector: assert property (
    pc_load |-> pc_value == RESET_PC && !core_reset ##1 !pc_load)
    else $error("bad vector load");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  chk_wr_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
endmodule : cpm_core_power_mode_sva

bind cpm_core_power_mode cpm_core_power_mode_sva u_sva (
  .aclk, .aresetn, .irq_pending, .irq_enable, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
  .s_axi_bready, .cpu_halt, .osc_enable, .periph_enable, .core_reset,
  .pc_load, .pc_value, .mode_state
);
`default_nettype wire

//--- tb/tb_core_power_mode_control.sv
// self-checking bench for the core power mode controller.
// assumes short watchdog and detector counts given at the instance.
`default_nettype none
module tb_core_power_mode_control
  import cpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T_CYC = 16;
  logic        aclk, aresetn, rst_pin_n, insn_retire, wdog_kick;
  logic [7:0]  irq_pending, irq_enable, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mode_state;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cpu_halt, osc_enable;
  logic        periph_enable, core_reset, pc_load;
  logic [15:0] pc_value;
  int          failures, n_checks;

  cpm_core_power_mode #(.WDOG_CYC(T_CYC), .DET_CYC(T_CYC)) uut (
    .aclk, .aresetn, .rst_pin_n, .insn_retire, .irq_pending, .irq_enable,
    .wdog_kick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_halt,
    .osc_enable, .periph_enable, .core_reset, .pc_load, .pc_value,
    .mode_state
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // settles one ns past the edge so registered outputs are seen updated
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic       aw_rdy, w_rdy, b_vld;
    logic [1:0] resp;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      // outputs come from flops: mid-cycle values hold at the next edge
      @(negedge aclk);
      aw_rdy = s_axi_awready;
      w_rdy = s_axi_wready;
      b_vld = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_rdy) s_axi_awvalid <= 1'b0;
      if (w_rdy) s_axi_wvalid <= 1'b0;
    end while (b_vld !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(resp), 32'(er));
    #1;
  endtask : wr

  // read data is only compared when an okay answer is expected
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic        ar_rdy, r_vld;
    logic [31:0] data;
    logic [1:0]  resp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_rdy = s_axi_arready;
      r_vld = s_axi_rvalid;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_rdy) s_axi_arvalid <= 1'b0;
    end while (r_vld !== 1'b1);
    s_axi_rready <= 1'b0;
    if (er == RESP_OKAY) chk(data, ed);
    chk(32'(resp), 32'(er));
    #1;
  endtask : rd

  task automatic sleep(input logic [31:0] v);
    wr(OFS_PCTL, v, RESP_OKAY);
    chk(32'(mode_state), 32'h0);
    insn_retire <= 1'b1;
    tick(1);
    insn_retire <= 1'b0;
    tick(3);
  endtask : sleep

  task automatic boot(input int lim, output int n);
    n = 0;
    while (pc_load !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    chk(32'(pc_load), 32'h1);
    chk(32'(pc_value), 32'(RESET_PC));
  endtask : boot

  task automatic pin_reset(output int n);
    rst_pin_n <= 1'b0;
    tick(3);
    rst_pin_n <= 1'b1;
    boot(40, n);
  endtask : pin_reset

  initial begin
    #(5 * 6000);
    failures++;
    $display("[ERR] %0t timeout", $time);
    conclude();
  end

  initial begin
    int n;
    failures = 0;
    n_checks = 0;
    aresetn = 1'b0;
    rst_pin_n = 1'b1;
    insn_retire = 1'b0;
    wdog_kick = 1'b0;
    irq_pending = 8'h00;
    irq_enable = 8'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    rd(OFS_PCTL, 32'(PCTL_RST), RESP_OKAY);
    rd(OFS_CFG, 32'(CFG_RST), RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(OFS_STAT, 32'h1, RESP_SLVERR);
    irq_pending <= 8'h04;
    sleep(32'hA9);
    chk(32'(mode_state), 32'h1);
    chk({29'h0, cpu_halt, osc_enable, periph_enable}, 32'h7);
    tick(8);
    chk(32'(mode_state), 32'h1);
    irq_enable <= 8'h04;
    tick(2);
    chk({30'h0, mode_state}, 32'h0);
    chk(32'(cpu_halt), 32'h0);
    rd(OFS_PCTL, 32'hA8, RESP_OKAY);
    irq_enable <= 8'h00;
    sleep(32'h1);
    pin_reset(n);
    rd(OFS_STAT, 32'h08, RESP_OKAY);
    wr(OFS_CFG, 32'h2, RESP_OKAY);
    wdog_kick <= 1'b1;
    tick(1);
    wdog_kick <= 1'b0;
    sleep(32'h1);
    chk(32'(mode_state), 32'h1);
    boot(60, n);
    wr(OFS_CFG, 32'h0, RESP_OKAY);
    rd(OFS_STAT, 32'h10, RESP_OKAY);
    irq_enable <= 8'h04;
    sleep(32'h2);
    chk({28'h0, mode_state, osc_enable, periph_enable}, 32'h8);
    tick(40);
    chk({30'h0, mode_state}, 32'h2);
    pin_reset(n);
    rd(OFS_STAT, 32'h08, RESP_OKAY);
    wr(OFS_CFG, 32'h1, RESP_OKAY);
    sleep(32'h2);
    boot(200, n);
    chk(32'(n > T_CYC / 2), 32'h1);
    rd(OFS_STAT, 32'h18, RESP_OKAY);
    conclude();
  end
endmodule : tb_core_power_mode_control
`default_nettype wire
